/* rpoc_pkg.sv */
// Function
// - active or sleep: codes 0 and 1 normal, 2 retained no access, 3 off
// - deeper modes: codes 0 and 2 retained, codes 1 and 3 off
// - second ram field in bits 3:2 decodes exactly like the first
// - slow rc trim in bits 4:1, 0000 lowest, 1111 highest, resets to 0111
// - slow rc off bit 0 stops the slow rc oscillator at once
// - no sleep cycles are allowed while the slow rc is off
// - crystal bit 7 turns amplitude regulation off; set for external clock
// - crystal bias current bits 6:3, 0000 minimum, 1111 maximum, reset 0x5
// - crystal bias resistor bits 2:1, 00 maximum, 11 minimum, reset 0x3
// - crystal bit 0 turns the crystal oscillator on
// - fast rc cap adjust bits 10:7, higher value lower frequency, reset 0xF
// - fast rc coarse range bits 6:5, rising frequency, codes 2 and 3 equal
// - fast rc off bit 0 stops it at once; sleep turns it off too
// - lowfreq rc regulator bias bits 11:8, 0x0 minimum, 0xF maximum, reset 0xA
// - lowfreq rc bit 7 adds unit capacitance, resets to 1
// - lowfreq rc cap adjust bits 6:2, 0x00 minimum, 0x1F maximum, reset 0x1F
// - lowfreq rc bit 1: 0 maximum resistance, 1 minimum resistance
// - lowfreq rc bit 0 turns it on, clear after reset
package rpoc_pkg;
	// printed offsets are register indices; byte address is four times index minus base
	localparam logic [31:0] RAM_POWER_IDX = 32'h50000018;
	localparam logic [31:0] SLOW_RC_IDX = 32'h50000020;
	localparam logic [31:0] SLOW_XTAL_IDX = 32'h50000022;
	localparam logic [31:0] FAST_RC_IDX = 32'h50000024;
	localparam logic [31:0] LOWFREQ_RC_IDX = 32'h50000026;
	localparam int ADDR_W = 8;
	localparam int REG_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int RAM1_LSB = 0;
	localparam int RAM2_LSB = 2;
	localparam int SRC_OFF_BIT = 0;
	localparam int SRC_TRIM_LSB = 1;
	localparam logic [3:0] SRC_TRIM_RST = 4'h7;
	localparam int XT_ON_BIT = 0;
	localparam int XT_RBIAS_LSB = 1;
	localparam logic [1:0] XT_RBIAS_RST = 2'h3;
	localparam int XT_CUR_LSB = 3;
	localparam logic [3:0] XT_CUR_RST = 4'h5;
	localparam int XT_AMP_OFF_BIT = 7;
	localparam int FRC_OFF_BIT = 0;
	localparam int FRC_BIAS_LSB = 1;
	localparam logic [3:0] FRC_BIAS_RST = 4'h8;
	localparam int FRC_RANGE_LSB = 5;
	localparam int FRC_CAP_LSB = 7;
	localparam logic [3:0] FRC_CAP_RST = 4'hF;
	localparam int LRC_ON_BIT = 0;
	localparam int LRC_RES_BIT = 1;
	localparam int LRC_CAP_LSB = 2;
	localparam logic [4:0] LRC_CAP_RST = 5'h1F;
	localparam int LRC_UNIT_BIT = 7;
	localparam logic LRC_UNIT_RST = 1'b1;
	localparam int LRC_BIAS_LSB = 8;
	localparam logic [3:0] LRC_BIAS_RST = 4'hA;

	localparam logic [15:0] RAM_POWER_RST = 16'h0000;
	localparam logic [15:0] SLOW_RC_RST = 16'(SRC_TRIM_RST) << SRC_TRIM_LSB;
	localparam logic [15:0] SLOW_XTAL_RST = (16'(XT_CUR_RST) << XT_CUR_LSB)
		| (16'(XT_RBIAS_RST) << XT_RBIAS_LSB);
	localparam logic [15:0] FAST_RC_RST = (16'(FRC_CAP_RST) << FRC_CAP_LSB)
		| (16'(FRC_BIAS_RST) << FRC_BIAS_LSB);
	localparam logic [15:0] LOWFREQ_RC_RST = (16'(LRC_BIAS_RST) << LRC_BIAS_LSB)
		| (16'(LRC_UNIT_RST) << LRC_UNIT_BIT) | (16'(LRC_CAP_RST) << LRC_CAP_LSB);

	typedef enum logic [1:0] {
		MODE_ACTIVE = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_DEEP = 2'b10
	} rpoc_mode_type;

	typedef enum logic [2:0] {
		SEL_RAM = 3'b000,
		SEL_SLOW_RC = 3'b001,
		SEL_SLOW_XTAL = 3'b010,
		SEL_FAST_RC = 3'b011,
		SEL_LOWFREQ_RC = 3'b100,
		SEL_NONE = 3'b111
	} rpoc_sel_type;

	typedef struct packed {
		logic accessible;
		logic retained;
		logic powered;
	} rpoc_ram_state_type;

	typedef struct packed {
		logic run;
		logic [3:0] freq_trim;
	} rpoc_slow_rc_type;

	typedef struct packed {
		logic on;
		logic amp_reg_off;
		logic [3:0] bias_current;
		logic [1:0] bias_resistor;
	} rpoc_crystal_type;

	typedef struct packed {
		logic run;
		logic [3:0] cap_adjust;
		logic [1:0] coarse_range;
		logic [3:0] bias_adjust;
	} rpoc_fast_rc_type;

	typedef struct packed {
		logic on;
		logic [3:0] regulator_bias;
		logic unit_cap;
		logic [4:0] cap_adjust;
		logic res_select;
	} rpoc_lowfreq_rc_type;
endpackage

/* rpoc_ctrl.sv */
`timescale 1ns/1ps
module rpoc_ctrl (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [rpoc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [rpoc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rpoc_pkg::rpoc_mode_type power_mode,
	output rpoc_pkg::rpoc_ram_state_type first_ram_power_state,
	output rpoc_pkg::rpoc_ram_state_type second_ram_power_state,
	output rpoc_pkg::rpoc_slow_rc_type slow_rc_ctrl,
	output logic sleep_allowed,
	output rpoc_pkg::rpoc_crystal_type slow_crystal_ctrl,
	output rpoc_pkg::rpoc_fast_rc_type fast_rc_ctrl,
	output rpoc_pkg::rpoc_lowfreq_rc_type lowfreq_rc_ctrl
);
	function automatic logic [rpoc_pkg::ADDR_W-1:0] byte_addr(input logic [31:0] idx);
		logic [31:0] rel;
		rel = (idx - rpoc_pkg::RAM_POWER_IDX) << 2;
		return rel[rpoc_pkg::ADDR_W-1:0];
	endfunction

	function automatic rpoc_pkg::rpoc_sel_type reg_sel(input logic [rpoc_pkg::ADDR_W-1:0] a);
		rpoc_pkg::rpoc_sel_type s;
		s = rpoc_pkg::SEL_NONE;
		if (a == byte_addr(rpoc_pkg::RAM_POWER_IDX)) begin
			s = rpoc_pkg::SEL_RAM;
		end else if (a == byte_addr(rpoc_pkg::SLOW_RC_IDX)) begin
			s = rpoc_pkg::SEL_SLOW_RC;
		end else if (a == byte_addr(rpoc_pkg::SLOW_XTAL_IDX)) begin
			s = rpoc_pkg::SEL_SLOW_XTAL;
		end else if (a == byte_addr(rpoc_pkg::FAST_RC_IDX)) begin
			s = rpoc_pkg::SEL_FAST_RC;
		end else if (a == byte_addr(rpoc_pkg::LOWFREQ_RC_IDX)) begin
			s = rpoc_pkg::SEL_LOWFREQ_RC;
		end
		return s;
	endfunction

	// only the two low byte lanes carry register bits; upper lanes are dropped
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = d[7:0];
		end
		if (strb[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	function automatic rpoc_pkg::rpoc_ram_state_type ram_decode(input logic [1:0] code,
		input rpoc_pkg::rpoc_mode_type mode);
		rpoc_pkg::rpoc_ram_state_type st;
		st = '0;
		unique case (mode)
			rpoc_pkg::MODE_ACTIVE, rpoc_pkg::MODE_SLEEP: begin
				st.accessible = ~code[1];
				st.retained = (code == 2'h2);
				st.powered = (code != 2'h3);
			end
			// unknown mode code is treated as deep: safest for retention
			default: begin
				st.accessible = 1'b0;
				st.retained = ~code[0];
				st.powered = ~code[0];
			end
		endcase
		return st;
	endfunction

	logic aw_full_reg;
	logic w_full_reg;
	logic [rpoc_pkg::ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic [15:0] ram_power_reg;
	logic [15:0] slow_rc_reg;
	logic [15:0] slow_xtal_reg;
	logic [15:0] fast_rc_reg;
	logic [15:0] lowfreq_rc_reg;

	logic aw_take;
	logic w_take;
	logic do_write;
	logic aw_full_next;
	logic w_full_next;
	logic bvalid_next;
	logic ar_take;
	logic rvalid_next;
	logic [rpoc_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	rpoc_pkg::rpoc_sel_type wr_sel;
	rpoc_pkg::rpoc_sel_type rd_sel;
	logic [15:0] rd_word;

	assign aw_take = s_axi_awvalid & awready_reg;
	assign w_take = s_axi_wvalid & wready_reg;
	assign do_write = (aw_full_reg | aw_take) & (w_full_reg | w_take) & ~bvalid_reg;
	assign aw_full_next = (aw_full_reg | aw_take) & ~do_write;
	assign w_full_next = (w_full_reg | w_take) & ~do_write;
	assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
	assign wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data = w_full_reg ? w_data_reg : s_axi_wdata;
	assign wr_strb = w_full_reg ? w_strb_reg : s_axi_wstrb;
	assign wr_sel = reg_sel(wr_addr);
	assign ar_take = s_axi_arvalid & arready_reg;
	assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
	assign rd_sel = reg_sel(s_axi_araddr);

	always_comb begin
		unique case (rd_sel)
			rpoc_pkg::SEL_RAM: rd_word = ram_power_reg;
			rpoc_pkg::SEL_SLOW_RC: rd_word = slow_rc_reg;
			rpoc_pkg::SEL_SLOW_XTAL: rd_word = slow_xtal_reg;
			rpoc_pkg::SEL_FAST_RC: rd_word = fast_rc_reg;
			rpoc_pkg::SEL_LOWFREQ_RC: rd_word = lowfreq_rc_reg;
			default: rd_word = 16'h0000;
		endcase
	end

	// write address and data are held separately so either may arrive first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			awready_reg <= ~aw_full_next & ~bvalid_next;
			wready_reg <= ~w_full_next & ~bvalid_next;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= rpoc_pkg::RESP_OKAY;
		end else begin
			bvalid_reg <= bvalid_next;
			if (do_write) begin
				bresp_reg <= (wr_sel == rpoc_pkg::SEL_NONE) ? rpoc_pkg::RESP_SLVERR
					: rpoc_pkg::RESP_OKAY;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= rpoc_pkg::RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= {16'h0000, rd_word};
				rresp_reg <= (rd_sel == rpoc_pkg::SEL_NONE) ? rpoc_pkg::RESP_SLVERR
					: rpoc_pkg::RESP_OKAY;
			end
		end
	end

	// full 16 bits are stored so reserved bits read back what was written
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ram_power_reg <= rpoc_pkg::RAM_POWER_RST;
		end else if (do_write && wr_sel == rpoc_pkg::SEL_RAM) begin
			ram_power_reg <= merge(ram_power_reg, wr_data, wr_strb);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slow_rc_reg <= rpoc_pkg::SLOW_RC_RST;
		end else if (do_write && wr_sel == rpoc_pkg::SEL_SLOW_RC) begin
			slow_rc_reg <= merge(slow_rc_reg, wr_data, wr_strb);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slow_xtal_reg <= rpoc_pkg::SLOW_XTAL_RST;
		end else if (do_write && wr_sel == rpoc_pkg::SEL_SLOW_XTAL) begin
			slow_xtal_reg <= merge(slow_xtal_reg, wr_data, wr_strb);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fast_rc_reg <= rpoc_pkg::FAST_RC_RST;
		end else if (do_write && wr_sel == rpoc_pkg::SEL_FAST_RC) begin
			fast_rc_reg <= merge(fast_rc_reg, wr_data, wr_strb);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lowfreq_rc_reg <= rpoc_pkg::LOWFREQ_RC_RST;
		end else if (do_write && wr_sel == rpoc_pkg::SEL_LOWFREQ_RC) begin
			lowfreq_rc_reg <= merge(lowfreq_rc_reg, wr_data, wr_strb);
		end
	end

	// ram state follows the mode live; software must keep the ram idle while changing it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			first_ram_power_state <= '0;
			second_ram_power_state <= '0;
		end else begin
			first_ram_power_state <= ram_decode(ram_power_reg[rpoc_pkg::RAM1_LSB +: 2],
				power_mode);
			second_ram_power_state <= ram_decode(ram_power_reg[rpoc_pkg::RAM2_LSB +: 2],
				power_mode);
		end
	end

	// oscillator controls are decoded from the stored word, not from the bus path,
	// so a disable lands two cycles after the write is taken
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slow_rc_ctrl <= '0;
			sleep_allowed <= 1'b0;
		end else begin
			slow_rc_ctrl.run <= ~slow_rc_reg[rpoc_pkg::SRC_OFF_BIT];
			slow_rc_ctrl.freq_trim <= slow_rc_reg[rpoc_pkg::SRC_TRIM_LSB +: 4];
			sleep_allowed <= ~slow_rc_reg[rpoc_pkg::SRC_OFF_BIT];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slow_crystal_ctrl <= '0;
		end else begin
			slow_crystal_ctrl.on <= slow_xtal_reg[rpoc_pkg::XT_ON_BIT];
			slow_crystal_ctrl.amp_reg_off <= slow_xtal_reg[rpoc_pkg::XT_AMP_OFF_BIT];
			slow_crystal_ctrl.bias_current <= slow_xtal_reg[rpoc_pkg::XT_CUR_LSB +: 4];
			slow_crystal_ctrl.bias_resistor <= slow_xtal_reg[rpoc_pkg::XT_RBIAS_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fast_rc_ctrl <= '0;
		end else begin
			fast_rc_ctrl.run <= ~fast_rc_reg[rpoc_pkg::FRC_OFF_BIT]
				& (power_mode == rpoc_pkg::MODE_ACTIVE);
			fast_rc_ctrl.cap_adjust <= fast_rc_reg[rpoc_pkg::FRC_CAP_LSB +: 4];
			// code 3 folded onto 2 so the analog side sees one setting for both
			fast_rc_ctrl.coarse_range <= fast_rc_reg[rpoc_pkg::FRC_RANGE_LSB + 1]
				? 2'h2 : fast_rc_reg[rpoc_pkg::FRC_RANGE_LSB +: 2];
			fast_rc_ctrl.bias_adjust <= fast_rc_reg[rpoc_pkg::FRC_BIAS_LSB +: 4];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lowfreq_rc_ctrl <= '0;
		end else begin
			lowfreq_rc_ctrl.on <= lowfreq_rc_reg[rpoc_pkg::LRC_ON_BIT];
			lowfreq_rc_ctrl.regulator_bias <= lowfreq_rc_reg[rpoc_pkg::LRC_BIAS_LSB +: 4];
			lowfreq_rc_ctrl.unit_cap <= lowfreq_rc_reg[rpoc_pkg::LRC_UNIT_BIT];
			lowfreq_rc_ctrl.cap_adjust <= lowfreq_rc_reg[rpoc_pkg::LRC_CAP_LSB +: 5];
			lowfreq_rc_ctrl.res_select <= lowfreq_rc_reg[rpoc_pkg::LRC_RES_BIT];
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
endmodule

/* rpoc_ctrl_assertions.sv */
`timescale 1ns/1ps
module rpoc_ctrl_assertions (
	input logic sys_clk,
	input logic rst,
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input rpoc_pkg::rpoc_mode_type power_mode,
	input rpoc_pkg::rpoc_ram_state_type first_ram_power_state,
	input rpoc_pkg::rpoc_ram_state_type second_ram_power_state,
	input rpoc_pkg::rpoc_slow_rc_type slow_rc_ctrl,
	input logic sleep_allowed,
	input rpoc_pkg::rpoc_fast_rc_type fast_rc_ctrl,
	input rpoc_pkg::rpoc_lowfreq_rc_type lowfreq_rc_ctrl
);
	logic wr_take;
	logic lo_mode;
	assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign lo_mode = power_mode inside {rpoc_pkg::MODE_ACTIVE, rpoc_pkg::MODE_SLEEP};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// control outputs lag their cause by one edge, hence the past mode
	chk_ram_active_map: assert property ($past(lo_mode) |->
		first_ram_power_state inside {3'h5, 3'h3, 3'h0}
		&& second_ram_power_state inside {3'h5, 3'h3, 3'h0}) else $error("bad ram state");
	chk_ram_deep_map: assert property (!$past(lo_mode) |->
		first_ram_power_state inside {3'h3, 3'h0}
		&& second_ram_power_state inside {3'h3, 3'h0}) else $error("bad deep ram state");
	chk_fast_sleep_off: assert property (fast_rc_ctrl.run |->
		$past(power_mode) == rpoc_pkg::MODE_ACTIVE) else $error("fast rc runs asleep");
	chk_sleep_gate: assert property (sleep_allowed == slow_rc_ctrl.run)
		else $error("sleep allowed with slow rc off");
	chk_range_fold: assert property (fast_rc_ctrl.coarse_range != 2'h3)
		else $error("coarse range code 3 not folded");
	chk_slow_off: assert property (wr_take && s_axi_awaddr == 8'h20 && s_axi_wstrb[0]
		&& s_axi_wdata[0] |-> ##2 !slow_rc_ctrl.run && !sleep_allowed) else $error("slow rc not off");
	chk_fast_off: assert property (wr_take && s_axi_awaddr == 8'h30 && s_axi_wstrb[0]
		&& s_axi_wdata[0] |-> ##2 !fast_rc_ctrl.run) else $error("fast rc not off");
	chk_lrc_on: assert property (wr_take && s_axi_awaddr == 8'h38 && s_axi_wstrb[0] |->
		##2 lowfreq_rc_ctrl.on == $past(s_axi_wdata[0], 2)) else $error("lowfreq rc enable wrong");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind rpoc_ctrl rpoc_ctrl_assertions chk_u (.*);

/* rpoc_ctrl_bench.sv */
`timescale 1ns/1ps
module rpoc_ctrl_bench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleep_allowed;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	rpoc_pkg::rpoc_mode_type power_mode = rpoc_pkg::MODE_ACTIVE;
	rpoc_pkg::rpoc_ram_state_type first_ram_power_state, second_ram_power_state;
	rpoc_pkg::rpoc_slow_rc_type slow_rc_ctrl;
	rpoc_pkg::rpoc_crystal_type slow_crystal_ctrl;
	rpoc_pkg::rpoc_fast_rc_type fast_rc_ctrl;
	rpoc_pkg::rpoc_lowfreq_rc_type lowfreq_rc_ctrl;
	int err_count = 0, n_compared = 0;
	logic [31:0] seed = 32'h00009FCF;
	logic [33:0] exp_q[$];
	logic [7:0] addr_t[5] = '{8'h00, 8'h20, 8'h28, 8'h30, 8'h38};
	logic [15:0] cur[5] = '{16'h0000, 16'h000E, 16'h002E, 16'h0790, 16'h0AFC};
	logic [31:0] v;

	always #5 sys_clk = ~sys_clk;

	rpoc_ctrl dut_u (.*);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [2:0] ram_dec(input logic [1:0] c);
		if (power_mode inside {rpoc_pkg::MODE_ACTIVE, rpoc_pkg::MODE_SLEEP})
			return (c < 2) ? 3'h5 : ((c == 2) ? 3'h3 : 3'h0);
		return c[0] ? 3'h0 : 3'h3;
	endfunction

	function automatic logic [33:0] want(input int k, input logic [15:0] w);
		case (k)
			0: want = {28'h0, ram_dec(w[1:0]), ram_dec(w[3:2])};
			1: want = {28'h0, ~w[0], ~w[0], w[4:1]};
			2: want = {26'h0, w[0], w[7], w[6:3], w[2:1]};
			3: want = {23'h0, ~w[0] && power_mode == rpoc_pkg::MODE_ACTIVE, w[10:7],
				(w[6:5] == 2'h3) ? 2'h2 : w[6:5], w[4:1]};
			default: want = {22'h0, w[0], w[11:8], w[7], w[6:2], w[1]};
		endcase
	endfunction

	function automatic logic [33:0] seen(input int k);
		case (k)
			0: seen = {28'h0, first_ram_power_state, second_ram_power_state};
			1: seen = {28'h0, slow_rc_ctrl.run, sleep_allowed, slow_rc_ctrl.freq_trim};
			2: seen = {26'h0, slow_crystal_ctrl};
			3: seen = {23'h0, fast_rc_ctrl};
			default: seen = {22'h0, lowfreq_rc_ctrl};
		endcase
	endfunction

	task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	// response checks live here so the drivers never judge their own answers
	always @(posedge sys_clk) begin
		if (s_axi_bvalid && s_axi_bready) cmp("bresp", exp_q.pop_front(), {32'h0, s_axi_bresp});
		if (s_axi_rvalid && s_axi_rready) cmp("read", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
	end

	// ready is held back one cycle so every answer has to stand
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
		logic pa, pw;
		logic [31:0] u;
		u = rnd();
		pa = 1'b1;
		pw = 1'b1;
		exp_q.push_back({32'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= {u[31:16], d};
		s_axi_wstrb <= {u[1:0], 2'h3};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw) begin
			@(posedge sys_clk);
			if (pa && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge sys_clk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
		exp_q.push_back({r, 16'h0, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask

	task automatic settle(input int k);
		repeat (2) @(posedge sys_clk);
		#1;
		cmp("outputs", want(k, cur[k]), seen(k));
		@(posedge sys_clk);
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int k = 0; k < 5; k++) begin
			rd(addr_t[k], cur[k], 2'h0);
			cmp("reset outputs", want(k, cur[k]), seen(k));
		end
		$display("test reset_values done");
		wr(8'h04, 16'hFFFF, 2'h2);
		rd(8'h04, 16'h0000, 2'h2);
		$display("test unmapped done");
		for (int k = 0; k < 5; k++) begin
			for (int j = 0; j < 3; j++) begin
				v = (j == 0) ? 32'hFFFF : ((j == 1) ? 32'h0 : rnd());
				cur[k] = v[15:0];
				wr(addr_t[k], cur[k], 2'h0);
				settle(k);
				rd(addr_t[k], cur[k], 2'h0);
			end
		end
		$display("test field_decode done");
		cur[3] = 16'h0790;
		wr(8'h30, cur[3], 2'h0);
		// mode 11 is outside the enum but still reachable on the pins
		for (int m = 0; m < 4; m++) begin
			power_mode <= rpoc_pkg::rpoc_mode_type'(2'(m));
			for (int c = 0; c < 16; c++) begin
				cur[0] = 16'(c);
				wr(8'h00, cur[0], 2'h0);
				settle(0);
			end
			cmp("fast rc", want(3, cur[3]), seen(3));
		end
		$display("test power_modes done");
		conclude();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		conclude();
	end
endmodule
